// File: pif_pkg.sv
package pif_pkg;

    // ------------------------------------------------------------
    // register word indices
    // ------------------------------------------------------------
    // printed offsets 0x0c, 0x8b, 0x8c are not all multiples of four,
    // so they are kept as indices and the byte address is four times each
    localparam logic [7:0] PIF_IDX_REQUEST_FLAGS = 8'h0C;
    localparam logic [7:0] PIF_IDX_CORE_CONTROL = 8'h8B;
    localparam logic [7:0] PIF_IDX_ENABLE_MASK = 8'h8C;
    localparam logic [7:0] PIF_IDX_SECOND_ENABLE = 8'h8D;
    localparam logic [7:0] PIF_IDX_IRQ_STATUS = 8'hC0;
    localparam logic [7:0] PIF_IDX_IRQ_MASK = 8'hC1;
    localparam logic [7:0] PIF_IDX_SOURCE_MODE = 8'hC2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PIF_BIT_OVERFLOW = 0;
    localparam int PIF_BIT_PERIOD = 1;
    localparam int PIF_BIT_CAPCMP = 2;
    localparam int PIF_BIT_SYNC = 3;
    localparam int PIF_BIT_TX = 4;
    localparam int PIF_BIT_RX = 5;
    localparam int PIF_BIT_RSVD = 6;
    localparam int PIF_BIT_PARALLEL = 7;
    localparam int PIF_BIT_GLOBAL = 7;
    localparam int PIF_BIT_PERIPH = 6;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] PIF_FLAGS_RESET = 8'h00;
    localparam logic [7:0] PIF_MASK_RESET = 8'h00;
    localparam logic [7:0] PIF_CTRL_RESET = 8'h00;
    localparam logic [7:0] PIF_SECOND_RESET = 8'h00;
    localparam logic [7:0] PIF_SW_FLAGS = 8'h8F;   // bits software clears
    localparam logic [7:0] PIF_ENABLE_WMASK = 8'h3F; // bits 7:6 reserved
    localparam logic [7:0] PIF_SECOND_WMASK = 8'h01;

    // ------------------------------------------------------------
    // capture/compare source mode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PIF_CC_OFF = 2'b00,
        PIF_CC_CAPTURE = 2'b01,
        PIF_CC_COMPARE = 2'b10,
        PIF_CC_PWM = 2'b11
    } pif_cc_mode_t;

endpackage

// File: pif_apb_decode.sv
`timescale 1ns/1ns
module pif_apb_decode
    import pif_pkg::*;
(
    input wire logic [11:0] paddr,
    output logic [7:0] index,
    output logic aligned
);
    // ------------------------------------------------------------
    // word index from byte address
    // ------------------------------------------------------------
    always_comb begin
        index = paddr[9:2];
        aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    end
endmodule

// File: pif_flags.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module pif_flags
    import pif_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic parallel_port_access,
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    input wire logic sync_port_done,
    input wire logic capcmp_one_capture,
    input wire logic capcmp_one_match,
    input wire logic period_match,
    input wire logic timer_overflow,
    output logic serial_rx_data_read,
    output logic serial_tx_data_write,
    output logic peripheral_irq,
    output logic capcmp_two_irq_enable,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] flags;       // latched software-cleared flags
        logic [7:0] enable_mask;
        logic [7:0] core_ctrl;
        logic [7:0] second_mask;
        pif_cc_mode_t cc_mode;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic rx_read;
        logic tx_write;
        logic periph_irq;
        logic irq;
    } pif_state_t;

    pif_state_t state_r;
    pif_state_t state_nxt;
    logic [7:0] index;
    logic aligned;
    logic [7:0] events;
    logic [7:0] flag_view;
    logic access;
    logic wr_hit;

    pif_apb_decode u_decode (
        .paddr(paddr),
        .index(index),
        .aligned(aligned)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a valid register index for this slave
    function automatic logic known_index(input logic [7:0] idx);
        known_index = (idx == PIF_IDX_REQUEST_FLAGS) || (idx == PIF_IDX_CORE_CONTROL)
            || (idx == PIF_IDX_ENABLE_MASK) || (idx == PIF_IDX_SECOND_ENABLE)
            || (idx == PIF_IDX_IRQ_STATUS) || (idx == PIF_IDX_IRQ_MASK)
            || (idx == PIF_IDX_SOURCE_MODE);
    endfunction

    // clears the bits where keep is zero, with set winning over clear
    function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                          input logic [7:0] keep);
        sticky = (cur & keep) | set;
    endfunction

    // ------------------------------------------------------------
    // event collection
    // ------------------------------------------------------------
    always_comb begin
        events = 8'h00;
        events[PIF_BIT_PARALLEL] = parallel_port_access;
        events[PIF_BIT_SYNC] = sync_port_done;
        // capture vs compare chooses which event sets the shared bit
        events[PIF_BIT_CAPCMP] = ((state_r.cc_mode == PIF_CC_CAPTURE) && capcmp_one_capture)
            || ((state_r.cc_mode == PIF_CC_COMPARE) && capcmp_one_match);
        events[PIF_BIT_PERIOD] = period_match;
        events[PIF_BIT_OVERFLOW] = timer_overflow;
        // buffer flags are live levels, not latches, so they clear with the buffer
        flag_view = state_r.flags & PIF_SW_FLAGS;
        flag_view[PIF_BIT_RX] = serial_rx_full;
        flag_view[PIF_BIT_TX] = serial_tx_empty;
        access = psel && penable;
        wr_hit = access && pwrite && aligned;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] keep;
        logic [7:0] wbyte;
        logic [7:0] stat_keep;
        logic [7:0] stat_set;
        keep = 8'hFF;
        wbyte = pwdata[7:0];
        stat_keep = 8'hFF;
        stat_set = 8'h00;
        state_nxt = state_r;
        state_nxt.ready = 1'b0;
        state_nxt.err = 1'b0;
        state_nxt.rx_read = 1'b0;
        state_nxt.tx_write = 1'b0;
        // flag writes: zero clears a software flag, a one never sets it
        if (wr_hit && index == PIF_IDX_REQUEST_FLAGS) begin
            keep = wbyte | ~PIF_SW_FLAGS;
        end
        // flags latch regardless of any enable bit
        state_nxt.flags = sticky(state_r.flags, events, keep) & PIF_SW_FLAGS;
        // slave answers in the second access cycle, one wait cycle via ready flop
        if (access && !state_r.ready) begin
            state_nxt.ready = 1'b1;
            state_nxt.err = !(aligned && known_index(index));
            state_nxt.rdata = 32'h0000_0000;
            if (aligned) begin
                case (index)
                    PIF_IDX_REQUEST_FLAGS: begin
                        state_nxt.rdata[7:0] = flag_view;
                    end
                    PIF_IDX_CORE_CONTROL: begin
                        state_nxt.rdata[7:0] = state_r.core_ctrl;
                    end
                    PIF_IDX_ENABLE_MASK: begin
                        state_nxt.rdata[7:0] = state_r.enable_mask;
                    end
                    PIF_IDX_SECOND_ENABLE: begin
                        state_nxt.rdata[7:0] = state_r.second_mask;
                    end
                    PIF_IDX_IRQ_STATUS: begin
                        state_nxt.rdata[7:0] = state_r.irq_status;
                    end
                    PIF_IDX_IRQ_MASK: begin
                        state_nxt.rdata[7:0] = state_r.irq_mask;
                    end
                    PIF_IDX_SOURCE_MODE: begin
                        state_nxt.rdata[1:0] = state_r.cc_mode;
                    end
                    default: begin
                        state_nxt.rdata = 32'h0000_0000;
                    end
                endcase
            end
            if (pwrite && aligned) begin
                case (index)
                    PIF_IDX_REQUEST_FLAGS: begin
                        // flag clears are handled above; no buffer strobe from here
                        state_nxt.tx_write = 1'b0;
                    end
                    PIF_IDX_CORE_CONTROL: begin
                        state_nxt.core_ctrl = wbyte;
                    end
                    PIF_IDX_ENABLE_MASK: begin
                        // reserved bits are forced clear in case software slips
                        state_nxt.enable_mask = wbyte & PIF_ENABLE_WMASK;
                    end
                    PIF_IDX_SECOND_ENABLE: begin
                        state_nxt.second_mask = wbyte & PIF_SECOND_WMASK;
                    end
                    PIF_IDX_IRQ_MASK: begin
                        state_nxt.irq_mask = wbyte;
                    end
                    PIF_IDX_SOURCE_MODE: begin
                        state_nxt.cc_mode = pif_cc_mode_t'(wbyte[1:0]);
                    end
                    default: begin
                        state_nxt.irq_mask = state_r.irq_mask;
                    end
                endcase
            end
            // write-one-to-clear on the status register
            if (pwrite && aligned && index == PIF_IDX_IRQ_STATUS) begin
                stat_keep = ~wbyte;
            end
        end
        // status copy: active events and buffer levels set the sticky bits, set beats clear
        stat_set = events | (flag_view & (8'h01 << PIF_BIT_RX))
            | (flag_view & (8'h01 << PIF_BIT_TX));
        state_nxt.irq_status = sticky(state_r.irq_status, stat_set, stat_keep);
        // enable gating toward the core: only enabled flags raise the peripheral line
        state_nxt.periph_irq = |(flag_view & state_r.enable_mask & PIF_ENABLE_WMASK)
            || (flag_view[PIF_BIT_PARALLEL] && state_r.enable_mask[PIF_BIT_PARALLEL]);
        state_nxt.irq = |(state_nxt.irq_status & state_r.irq_mask);
        // flush pulse tied to the flag register is unused, buffer strobes follow
        state_nxt.rx_read = 1'b0;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '{flags: PIF_FLAGS_RESET, enable_mask: PIF_MASK_RESET,
                         core_ctrl: PIF_CTRL_RESET, second_mask: PIF_SECOND_RESET,
                         cc_mode: PIF_CC_OFF, irq_status: 8'h00, irq_mask: 8'h00,
                         rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0,
                         rx_read: 1'b0, tx_write: 1'b0, periph_irq: 1'b0, irq: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign prdata = state_r.rdata;
    assign pready = state_r.ready;
    assign pslverr = state_r.err;
    assign serial_rx_data_read = state_r.rx_read;
    assign serial_tx_data_write = state_r.tx_write;
    assign peripheral_irq = state_r.periph_irq;
    assign capcmp_two_irq_enable = state_r.second_mask[0];
    assign irq = state_r.irq;

endmodule

// File: pif_flags_monitor.sv
`timescale 1ns/1ns
module pif_flags_chk
    import pif_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    input wire logic serial_rx_data_read,
    input wire logic serial_tx_data_write
);
    // ------------------------------------------------------------
    // bus timing and flag register checks
    // ------------------------------------------------------------
    localparam logic [11:0] A_FLAGS = {2'b00, PIF_IDX_REQUEST_FLAGS, 2'b00};
    localparam logic [11:0] A_ENABLE = {2'b00, PIF_IDX_ENABLE_MASK, 2'b00};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // an access still waiting, and a finished read of one register
    sequence s_req;
        psel && penable && !pready;
    endsequence
    sequence s_rd(logic [11:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    a_pready_answer: assert property (s_req |=> pready)
        else $error("no answer one cycle after an access");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_slverr_unaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned access not refused");
    a_rx_flag_live: assert property (s_rd(A_FLAGS) |-> prdata[5] == $past(serial_rx_full))
        else $error("receive flag does not follow buffer state");
    a_tx_flag_live: assert property (s_rd(A_FLAGS) |-> prdata[4] == $past(serial_tx_empty))
        else $error("transmit flag does not follow buffer state");
    a_flag_reserved: assert property (s_rd(A_FLAGS) |-> !prdata[6] && prdata[31:8] == 24'h0)
        else $error("reserved flag bits read nonzero");
    a_enable_reserved: assert property (s_rd(A_ENABLE) |-> prdata[7:6] == 2'b00)
        else $error("reserved enable bits read nonzero");
    a_no_buffer_strobe: assert property (!serial_rx_data_read && !serial_tx_data_write)
        else $error("buffer strobe raised by flag block");
endmodule
bind pif_flags pif_flags_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .serial_rx_full, .serial_tx_empty, .serial_rx_data_read,
    .serial_tx_data_write);

// File: pif_periph_model.sv
`timescale 1ns/1ns
module pif_periph_model (
    input wire logic pclk,
    output logic parallel_port_access,
    output logic serial_rx_full,
    output logic serial_tx_empty,
    output logic sync_port_done,
    output logic capcmp_one_capture,
    output logic capcmp_one_match,
    output logic period_match,
    output logic timer_overflow
);
    // ------------------------------------------------------------
    // peripheral condition sources
    // ------------------------------------------------------------
    // one vector holds all sources; bit 6 carries the compare match
    logic [7:0] ev = 8'h00;
    assign parallel_port_access = ev[7];
    assign capcmp_one_match = ev[6];
    assign serial_rx_full = ev[5];
    assign serial_tx_empty = ev[4];
    assign sync_port_done = ev[3];
    assign capcmp_one_capture = ev[2];
    assign period_match = ev[1];
    assign timer_overflow = ev[0];
    // events last exactly one cycle, like a real timer or port strobe
    task automatic pulse(input int b);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev[b] <= 1'b0;
    endtask
    // buffer states are levels, held until changed again
    task automatic level(input int b, input logic v);
        @(posedge pclk);
        ev[b] <= v;
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ns
module testbench
    import pif_pkg::*;
;
    // ------------------------------------------------------------
    // signals, clock and instances
    // ------------------------------------------------------------
    localparam logic [7:0] FL = PIF_IDX_REQUEST_FLAGS;
    localparam logic [7:0] EN = PIF_IDX_ENABLE_MASK;
    localparam logic [7:0] MD = PIF_IDX_SOURCE_MODE;
    localparam logic [7:0] ST = PIF_IDX_IRQ_STATUS;
    localparam logic [7:0] MK = PIF_IDX_IRQ_MASK;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, err;
    wire logic [7:0] ev;
    wire logic [4:0] o;
    int num_errors = 0;
    int n_tests = 0;
    // free-running 100 MHz clock
    always #5 pclk = ~pclk;
    pif_periph_model i_peri (.pclk(pclk), .parallel_port_access(ev[7]), .serial_rx_full(ev[5]),
        .serial_tx_empty(ev[4]), .sync_port_done(ev[3]), .capcmp_one_capture(ev[2]),
        .capcmp_one_match(ev[6]), .period_match(ev[1]), .timer_overflow(ev[0]));
    pif_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .parallel_port_access(ev[7]), .serial_rx_full(ev[5]),
        .serial_tx_empty(ev[4]), .sync_port_done(ev[3]), .capcmp_one_capture(ev[2]),
        .capcmp_one_match(ev[6]), .period_match(ev[1]), .timer_overflow(ev[0]),
        .serial_rx_data_read(o[0]), .serial_tx_data_write(o[1]), .peripheral_irq(o[2]),
        .capcmp_two_irq_enable(o[3]), .irq(o[4]));
    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // request held until pready is seen at an edge; a hang ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // look at the settled answer mid-cycle, then release on the edge that samples it
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
        rdv = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        apb(1'b1, ad(i), d);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        apb(1'b0, ad(i), 32'h0);
        chk($sformatf("reg %h", i), rdv, e);
    endtask
    // outputs are registered, so allow a few edges before looking
    task automatic look(input int i, input logic e);
        repeat (3) @(negedge pclk);
        chk($sformatf("output %0d", i), {31'h0, o[i]}, {31'h0, e});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd(FL, 32'h0);
        rd(EN, 32'h0);
        wr(EN, 32'hFF);
        rd(EN, 32'h3F);
        wr(PIF_IDX_SECOND_ENABLE, 32'hFF);
        rd(PIF_IDX_SECOND_ENABLE, 32'h1);
        look(3, 1'b1);
    endtask
    // each event sets its flag; ones written keep it, zeros clear it
    task automatic t_flags;
        int bt[5] = '{7, 3, 2, 1, 0};
        wr(MD, 32'h1);
        foreach (bt[j]) begin
            i_peri.pulse(bt[j]);
            rd(FL, 32'h1 << bt[j]);
            wr(FL, 32'hFF);
            rd(FL, 32'h1 << bt[j]);
            wr(FL, 32'h0);
            rd(FL, 32'h0);
        end
        wr(MD, 32'h2);
        i_peri.pulse(2);
        rd(FL, 32'h0);
        i_peri.pulse(6);
        rd(FL, 32'h4);
        wr(FL, 32'h0);
    endtask
    // buffer flags follow the buffers and ignore software writes
    task automatic t_levels;
        i_peri.level(5, 1'b1);
        wr(FL, 32'h0);
        rd(FL, 32'h20);
        i_peri.level(5, 1'b0);
        i_peri.level(4, 1'b1);
        rd(FL, 32'h10);
        i_peri.level(4, 1'b0);
        rd(FL, 32'h0);
    endtask
    // only the source's own enable bit lets it reach the interrupt
    task automatic t_enables;
        for (int b = 0; b < 6; b++) begin
            if (b >= 4)
                i_peri.level(b, 1'b1);
            else
                i_peri.pulse(b == 2 ? 6 : b);
            wr(EN, 32'h3F & ~(32'h1 << b));
            look(2, 1'b0);
            wr(EN, 32'h1 << b);
            look(2, 1'b1);
            if (b >= 4)
                i_peri.level(b, 1'b0);
            else
                wr(FL, 32'h0);
        end
        wr(EN, 32'h0);
    endtask
    task automatic t_irq;
        wr(ST, 32'hFF);
        wr(MK, 32'h1);
        look(4, 1'b0);
        i_peri.pulse(0);
        look(4, 1'b1);
        wr(ST, 32'h1);
        look(4, 1'b0);
        wr(MK, 32'h0);
        i_peri.pulse(0);
        look(4, 1'b0);
        rd(ST, 32'h1);
    endtask
    task automatic t_refused;
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped data", rdv, 32'h0);
        apb(1'b1, ad(EN) + 12'h2, 32'hFF);
        chk("unaligned error", {31'h0, err}, 32'h1);
        rd(EN, 32'h0);
    endtask
    // reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_flags();
        t_levels();
        t_enables();
        t_irq();
        t_refused();
        print_verdict();
    end
endmodule
